/* rtl/asr_top.sv */
/*
 Asynchronous serial transmitter and receiver with a baud generator,
 one-character transmit holding register and two-character receive FIFO.
 Assumes one 25 MHz clock, a register port with read data one cycle
 after the read strobe, and an unsynchronised receive pin.
*/
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE1: shift_empty set idle, cleared on load, read-only
// RULE2: shift_empty clear until frame done, no irq
// RULE3: nine-bit select sends ninth bit as MSB
// RULE4: host writes ninth bit before data byte
// RULE5: all nine bits loaded right after write
// RULE6: ninth bit set marks byte as address
// RULE7: host sets divisor and enables before transmit
// RULE8: polarity invert flips idle and data levels
// RULE9: transmit enable sets tx_empty_flag at once
// RULE10: enabled tx_empty_flag raises interrupt at once
// RULE11: writing transmit data starts a character
// RULE12: receiver runs only when enabled and asynchronous
// RULE13: sample at sixteen times baud rate
// RULE14: finished character goes into two-entry FIFO
// RULE15: reception starts on falling receive edge
// RULE16: half-bit recheck, abort silently if high
// RULE17: full bit to each centre, majority vote
// RULE18: stop bit zero sets framing error
// RULE19: push character and flag after stop bit
// RULE20: reading receive data pops oldest character
// RULE21: overrun blocks reception until cleared
// RULE22: third character on full FIFO sets overrun
// RULE23: framing_error shows oldest character's error
// RULE24: tx_empty_flag set when enabled and holding empty
// RULE25: least significant bit first both ways
// RULE26: one baud count drives transmit and receive
module asr_top
	import asr_pkg::*;
(
	input wire logic clock, // 25 MHz system clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [2:0] addr, // Register index
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire logic receive_pin, // Serial input
	output logic transmit_pin, // Serial output level
	output logic transmit_pin_oe, // Transmit pin driven
	output logic irq_request // Interrupt to the core
);
	// ------------------------------------------------------------
	// Assertion defaults
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] tx_status_r; // transmit_status_control
	logic [7:0] rx_status_r; // receive_status_control
	logic [7:0] baud_ctrl_r; // baud_control
	logic [7:0] div_lo_r; // baud_divisor_low
	logic [7:0] div_hi_r; // baud_divisor_high
	logic [7:0] irq_ctrl_r; // interrupt enables
	logic [7:0] rdata_r; // registered read data
	logic wr_txdata; // transmit data written
	logic rd_rxdata; // receive data read
	logic port_en; // port_enable
	logic tx_on; // transmitter running
	logic rx_on; // receiver running

	assign wr_txdata = wr_stb && (addr == OFS_TX_DATA);
	assign rd_rxdata = rd_stb && (addr == OFS_RX_DATA);
	assign port_en = rx_status_r[RXS_PEN];
	assign tx_on = tx_status_r[TXS_EN] && !tx_status_r[TXS_SYNC] && port_en;

	// Control register writes, only writable bits stored
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_status_r <= CTRL_RESET;
			rx_status_r <= CTRL_RESET;
			baud_ctrl_r <= CTRL_RESET;
			div_lo_r <= DIV_RESET;
			div_hi_r <= DIV_RESET;
			irq_ctrl_r <= CTRL_RESET;
		end else if (wr_stb) begin
			unique case (addr)
				OFS_TX_STATUS: tx_status_r <= wdata & TXS_WMASK;
				OFS_RX_STATUS: rx_status_r <= wdata & RXS_WMASK;
				OFS_BAUD_CTRL: baud_ctrl_r <= wdata & BDC_WMASK;
				OFS_DIV_LO: div_lo_r <= wdata;
				OFS_DIV_HI: div_hi_r <= wdata;
				OFS_IRQ_CTRL: irq_ctrl_r <= wdata & IRQ_WMASK;
				default: ; // Data registers handled elsewhere
			endcase
		end
	end

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	logic [17:0] baud_cnt_r; // Cycle counter
	logic [17:0] baud_limit; // Cycles per tick minus one
	logic tick; // Sixteen-times-baud enable
	logic [15:0] divisor; // Effective divisor

	// Narrow mode uses only the low byte; slow mode adds divide by 4 with the narrow divisor only
	assign divisor = baud_ctrl_r[BDC_WIDE] ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
	assign baud_limit = (!tx_status_r[TXS_HSPD] && !baud_ctrl_r[BDC_WIDE]) ?
		{divisor, 2'b11} : {2'b00, divisor};
	assign tick = port_en && (baud_cnt_r >= baud_limit); // Passing the limit also ends a count

	// One count feeds both directions
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			baud_cnt_r <= 18'h00000;
		end else if (!port_en || tick) begin
			baud_cnt_r <= 18'h00000; // RULE26
		end else begin
			baud_cnt_r <= baud_cnt_r + 18'h00001;
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [7:0] hold_data_r; // transmit_data_reg contents
	logic hold_full_r; // Character waiting
	logic [10:0] tx_shift_r; // transmit_shifter frame
	logic [3:0] tx_bits_r; // Bits left in frame
	logic [3:0] tx_ph_r; // Tick within bit
	logic tx_load; // Holding to shifter move
	logic tx_busy; // Shifter occupied
	logic tx_level_r; // Pin level before inversion
	logic tx_empty_flag; // Holding register empty
	logic shift_empty; // Shifter empty

	assign tx_busy = (tx_bits_r != 4'h0);
	assign shift_empty = !tx_busy; // RULE1
	assign tx_load = tx_on && hold_full_r && !tx_busy; // RULE5
	assign tx_empty_flag = tx_on && !hold_full_r; // RULE9 RULE24

	// Holding register, write fills, load empties
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hold_data_r <= 8'h00;
			hold_full_r <= 1'b0;
		end else if (!port_en) begin
			hold_full_r <= 1'b0;
		end else if (wr_txdata) begin
			hold_data_r <= wdata; // RULE11
			hold_full_r <= 1'b1;
		end else if (tx_load) begin
			hold_full_r <= 1'b0;
		end
	end

	// Shifter: start, data LSB first, optional ninth, stop
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_shift_r <= 11'h7ff;
			tx_bits_r <= 4'h0;
			tx_ph_r <= 4'h0;
		end else if (!tx_on) begin
			tx_shift_r <= 11'h7ff;
			tx_bits_r <= 4'h0;
			tx_ph_r <= 4'h0;
		end else if (tx_load) begin
			// Ninth bit taken from the control register at load
			if (tx_status_r[TXS_NINE]) begin
				tx_shift_r <= {1'b1, tx_status_r[TXS_NINTH], hold_data_r, 1'b0}; // RULE3 RULE6
				tx_bits_r <= FRAME_9;
			end else begin
				tx_shift_r <= {2'b11, hold_data_r, 1'b0}; // RULE25
				tx_bits_r <= FRAME_8;
			end
			tx_ph_r <= 4'h0;
		end else if (tx_busy && tick) begin
			tx_ph_r <= tx_ph_r + 4'h1;
			if (tx_ph_r == TICK_LAST) begin
				tx_shift_r <= {1'b1, tx_shift_r[10:1]};
				tx_bits_r <= tx_bits_r - 4'h1; // RULE2
			end
		end
	end

	// Pin level registered, idles at mark
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_level_r <= 1'b1;
		end else begin
			tx_level_r <= tx_busy ? tx_shift_r[0] : 1'b1;
		end
	end

	assign transmit_pin = tx_level_r ^ baud_ctrl_r[BDC_INV]; // RULE8
	assign transmit_pin_oe = tx_on;

	// ------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------
	logic [2:0] rx_sync_r; // Three-stage chain
	logic rx_f_r; // Filtered line level
	logic rx_prev_r; // Previous filtered level

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync_r <= 3'b111;
			rx_f_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_sync_r <= {rx_sync_r[1:0], receive_pin};
			if (rx_sync_r[1] == rx_sync_r[2]) begin
				rx_f_r <= rx_sync_r[2];
			end
			rx_prev_r <= rx_f_r;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	asr_rx_state_t rx_st_r; // Receiver state
	logic [3:0] rx_ph_r; // Tick within bit
	logic [3:0] rx_cnt_r; // Data bits taken
	logic [8:0] rx_shift_r; // receive_shifter
	logic vote1_r; // First vote
	logic vote2_r; // Second vote
	logic majority; // Voted bit
	logic rx_push; // Character complete
	logic [9:0] rx_word; // Error, ninth, data
	logic overrun_r; // overrun_error
	logic [3:0] rx_last; // Index of last data bit

	assign majority = (vote1_r & vote2_r) | (vote1_r & rx_f_r) | (vote2_r & rx_f_r); // RULE17
	assign rx_on = rx_status_r[RXS_CONTINUOUS_RECEIVE_ENABLE] && !tx_status_r[TXS_SYNC] && port_en && !overrun_r; // RULE12 RULE21
	assign rx_last = rx_status_r[RXS_NINE] ? 4'h8 : 4'h7;
	assign rx_push = (rx_st_r == RX_STOP) && tick && (rx_ph_r == TICK_LAST); // RULE19
	assign rx_word = {!majority, // RULE18
		rx_status_r[RXS_NINE] ? rx_shift_r : {1'b0, rx_shift_r[8:1]}};

	// Votes taken on the two ticks before each data and stop bit centre
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vote1_r <= 1'b1;
			vote2_r <= 1'b1;
		end else if (tick) begin
			if (rx_ph_r == TICK_VOTE1) begin
				vote1_r <= rx_f_r;
			end
			if (rx_ph_r == TICK_VOTE2) begin
				vote2_r <= rx_f_r;
			end
		end
	end

	// Bit recovery state machine
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_r <= RX_IDLE;
			rx_ph_r <= 4'h0;
			rx_cnt_r <= 4'h0;
			rx_shift_r <= 9'h000;
		end else if (!rx_on) begin
			rx_st_r <= RX_IDLE;
			rx_ph_r <= 4'h0;
		end else begin
			unique case (rx_st_r)
				RX_IDLE: begin
					// Falling edge starts a character
					if (rx_prev_r && !rx_f_r) begin
						rx_st_r <= RX_START; // RULE15
						rx_ph_r <= 4'h0;
					end
				end
				RX_START: if (tick) begin
					rx_ph_r <= rx_ph_r + 4'h1; // RULE13
					if (rx_ph_r == TICK_HALF) begin
						// Glitch: back to edge search, no error
						rx_st_r <= rx_f_r ? RX_IDLE : RX_DATA; // RULE16
						rx_ph_r <= 4'h0;
						rx_cnt_r <= 4'h0;
					end
				end
				RX_DATA: if (tick) begin
					rx_ph_r <= rx_ph_r + 4'h1;
					if (rx_ph_r == TICK_LAST) begin
						rx_shift_r <= {majority, rx_shift_r[8:1]}; // RULE25
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == rx_last) begin
							rx_st_r <= RX_STOP;
						end
					end
				end
				RX_STOP: if (tick) begin
					rx_ph_r <= rx_ph_r + 4'h1;
					if (rx_ph_r == TICK_LAST) begin
						rx_st_r <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receive FIFO, two entries
	// ------------------------------------------------------------
	logic [9:0] fifo_mem_r [0:1]; // Error, ninth, data
	logic fifo_wp_r; // Write pointer
	logic fifo_rp_r; // Read pointer
	logic [1:0] fifo_cnt_r; // Occupancy
	logic fifo_pop; // Oldest removed
	logic fifo_keep; // Address filter pass
	logic fifo_wr; // Entry written
	logic fifo_over; // Third character lost

	assign fifo_pop = rd_rxdata && (fifo_cnt_r != 2'h0); // RULE20
	assign fifo_keep = !(rx_status_r[RXS_ADDR] && rx_status_r[RXS_NINE] && !rx_word[8]);
	assign fifo_over = rx_push && fifo_keep && (fifo_cnt_r == 2'h2) && !fifo_pop;
	assign fifo_wr = rx_push && fifo_keep && !fifo_over; // RULE14

	always_ff @(posedge clock) begin
		if (fifo_wr) begin
			fifo_mem_r[fifo_wp_r] <= rx_word;
		end
	end

	// Pointers and count; port disable flushes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fifo_wp_r <= 1'b0;
			fifo_rp_r <= 1'b0;
			fifo_cnt_r <= 2'h0;
		end else if (!port_en) begin
			fifo_wp_r <= 1'b0;
			fifo_rp_r <= 1'b0;
			fifo_cnt_r <= 2'h0;
		end else begin
			if (fifo_wr) begin
				fifo_wp_r <= !fifo_wp_r;
			end
			if (fifo_pop) begin
				fifo_rp_r <= !fifo_rp_r;
			end
			fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_wr} - {1'b0, fifo_pop};
		end
	end

	// Overrun: set wins, cleared by continuous receive disable or port disable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			overrun_r <= 1'b0;
		end else if (fifo_over) begin
			overrun_r <= 1'b1; // RULE22
		end else if (!rx_status_r[RXS_CONTINUOUS_RECEIVE_ENABLE] || !port_en) begin
			overrun_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Status, interrupt and read data
	// ------------------------------------------------------------
	logic [9:0] fifo_top; // Oldest entry or zero
	logic rx_ready_flag; // Unread character present

	assign fifo_top = (fifo_cnt_r != 2'h0) ? fifo_mem_r[fifo_rp_r] : 10'h000; // RULE23
	assign rx_ready_flag = fifo_cnt_r != 2'h0;
	assign irq_request = irq_ctrl_r[IRQ_GIE] && irq_ctrl_r[IRQ_PEIE] &&
		((tx_empty_flag && irq_ctrl_r[IRQ_TXIE]) || (rx_ready_flag && irq_ctrl_r[IRQ_RXIE])); // RULE10

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else if (rd_stb) begin
			unique case (addr)
				OFS_TX_STATUS: rdata_r <= tx_status_r | {6'h00, shift_empty, 1'b0}; // RULE1
				OFS_RX_STATUS: rdata_r <= rx_status_r | {5'h00, fifo_top[9], overrun_r, fifo_top[8]};
				OFS_BAUD_CTRL: rdata_r <= baud_ctrl_r;
				OFS_DIV_LO: rdata_r <= div_lo_r;
				OFS_DIV_HI: rdata_r <= div_hi_r;
				OFS_TX_DATA: rdata_r <= hold_data_r;
				OFS_RX_DATA: rdata_r <= fifo_top[7:0];
				OFS_IRQ_CTRL: rdata_r <= irq_ctrl_r | {6'h00, rx_ready_flag, tx_empty_flag};
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign rdata = rdata_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_tx_write_free;
		wr_txdata && tx_on && !hold_full_r && !tx_busy;
	endsequence

	sequence s_load_then_busy;
		tx_load ##1 (!shift_empty && tx_bits_r >= FRAME_8);
	endsequence

	AST_LOAD_AFTER_WRITE: assert property (s_tx_write_free |=> s_load_then_busy) // RULE5
		else $error("character not loaded after transmit write");
	AST_EMPTY_CLEARS: assert property (tx_load |=> !shift_empty) // RULE1
		else $error("shift_empty not cleared on load");
	AST_EMPTY_STAYS: assert property ((tx_bits_r > 4'h1) && tx_on |=> !shift_empty) // RULE2
		else $error("shift_empty set before frame end");
	AST_NINE_BIT_FRAME: assert property (tx_load && tx_status_r[TXS_NINE] |=>
		tx_bits_r == FRAME_9 && tx_shift_r[9] == $past(tx_status_r[TXS_NINTH])) // RULE3
		else $error("nine-bit frame wrong");
	AST_ENABLE_SETS_FLAG: assert property (wr_stb && addr == OFS_TX_STATUS && wdata[TXS_EN] &&
		!wdata[TXS_SYNC] && port_en && !hold_full_r && !wr_txdata |=> tx_empty_flag) // RULE9
		else $error("transmit enable did not set flag");
	AST_IRQ_TX: assert property (wr_stb && addr == OFS_IRQ_CTRL && wdata[IRQ_TXIE] && wdata[IRQ_PEIE] &&
		wdata[IRQ_GIE] && tx_empty_flag |=> irq_request) // RULE10
		else $error("no interrupt after enabling with transmit flag set");
	AST_START_ABORT: assert property (rx_on && rx_st_r == RX_START && tick && rx_ph_r == TICK_HALF &&
		rx_f_r |=> rx_st_r == RX_IDLE && !overrun_r) // RULE16
		else $error("glitch start bit not aborted");
	AST_RX_OFF_IDLE: assert property (!rx_on |=> rx_st_r == RX_IDLE) // RULE12
		else $error("receiver active while disabled");
	AST_OVERRUN_SET: assert property (fifo_over |=> overrun_r && fifo_cnt_r == 2'h2) // RULE22
		else $error("overrun not flagged or character stored");
	AST_POP_LAST: assert property (fifo_pop && fifo_cnt_r == 2'h1 && !fifo_wr |=>
		fifo_cnt_r == 2'h0 && !rx_ready_flag) // RULE20
		else $error("read did not remove character");
	AST_PUSH_FLAG: assert property (fifo_wr |=> rx_ready_flag) // RULE19
		else $error("receive flag not set after push");
endmodule

`default_nettype wire

/* rtl/asr_pkg.sv */
/*
 Constants for the asynchronous serial transmitter and receiver:
 register offsets, field positions, reset values and bit timing.
 Assumes a register port with a 3-bit word address.
*/
package asr_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [2:0] OFS_TX_STATUS = 3'h0; // transmit_status_control
	localparam logic [2:0] OFS_RX_STATUS = 3'h1; // receive_status_control
	localparam logic [2:0] OFS_BAUD_CTRL = 3'h2; // baud_control
	localparam logic [2:0] OFS_DIV_LO = 3'h3; // baud_divisor_low
	localparam logic [2:0] OFS_DIV_HI = 3'h4; // baud_divisor_high
	localparam logic [2:0] OFS_TX_DATA = 3'h5; // transmit_data
	localparam logic [2:0] OFS_RX_DATA = 3'h6; // receive data, read pops
	localparam logic [2:0] OFS_IRQ_CTRL = 3'h7; // flags and enables

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TXS_NINE = 6; // nine_bit_tx_select
	localparam int TXS_EN = 5; // transmit_enable
	localparam int TXS_SYNC = 4; // synchronous select
	localparam int TXS_HSPD = 2; // high_speed_baud_select
	localparam int TXS_EMPTY = 1; // shift_empty, read-only
	localparam int TXS_NINTH = 0; // tx_ninth_bit
	localparam int RXS_PEN = 7; // port_enable
	localparam int RXS_NINE = 6; // nine_bit_rx_select
	localparam int RXS_CONTINUOUS_RECEIVE_ENABLE = 4; // continuous_receive_enable
	localparam int RXS_ADDR = 3; // address_detect_enable
	localparam int RXS_FRAMING_ERROR = 2; // framing_error, read-only
	localparam int RXS_OVERRUN_ERROR = 1; // overrun_error, read-only
	localparam int RXS_NINTH = 0; // received ninth bit, read-only
	localparam int BDC_INV = 4; // tx_polarity_invert
	localparam int BDC_WIDE = 3; // wide_divisor_select
	localparam int IRQ_TXF = 0; // tx_empty_flag, read-only
	localparam int IRQ_RXF = 1; // rx_ready_flag, read-only
	localparam int IRQ_TXIE = 2; // tx_empty_irq_enable
	localparam int IRQ_RXIE = 3; // receive irq enable
	localparam int IRQ_PEIE = 4; // peripheral_irq_enable
	localparam int IRQ_GIE = 5; // global_irq_enable

	// ------------------------------------------------------------
	// Writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] TXS_WMASK = 8'h75;
	localparam logic [7:0] RXS_WMASK = 8'hd8;
	localparam logic [7:0] BDC_WMASK = 8'h18;
	localparam logic [7:0] IRQ_WMASK = 8'h3c;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h00;

	// ------------------------------------------------------------
	// Bit timing in sampling ticks, frame lengths in bits
	// ------------------------------------------------------------
	localparam logic [3:0] TICK_LAST = 4'hf; // 16 ticks per bit
	localparam logic [3:0] TICK_HALF = 4'h7; // centre of start bit
	localparam logic [3:0] TICK_VOTE1 = 4'hd; // first vote
	localparam logic [3:0] TICK_VOTE2 = 4'he; // second vote
	localparam logic [3:0] FRAME_8 = 4'ha; // start, 8 data, stop
	localparam logic [3:0] FRAME_9 = 4'hb; // start, 9 data, stop

	// Receiver states
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} asr_rx_state_t;
endpackage

/* tb/asr_remote.sv */
/*
 Remote serial device: sends frames into the receive line and
 decodes frames seen on the transmit line.
 Assumes 16 clocks per bit and non-inverted levels.
*/
`timescale 1ns/1ns
`default_nettype none
module asr_remote (
	input wire logic clock, // System clock
	output logic rx_line, // Line into the device
	input wire logic tx_line // Line from the device
);
	localparam int BIT = 16; // Clocks per bit
	initial rx_line = 1'b1; // Idle mark

	// ----------------------------------------
	// Sender, LSB first, one stop bit
	// ----------------------------------------
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(posedge clock);
		rx_line <= 1'b0;
		repeat (BIT) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			rx_line <= d[i];
			repeat (BIT) @(posedge clock);
		end
		rx_line <= stop;
		repeat (BIT) @(posedge clock);
		rx_line <= 1'b1; // Idle gap
		repeat (BIT) @(posedge clock);
	endtask

	// Short low pulse, too short for a start bit
	task automatic glitch(input int n);
		@(posedge clock);
		rx_line <= 1'b0;
		repeat (n) @(posedge clock);
		rx_line <= 1'b1;
	endtask

	// ----------------------------------------
	// Decoder, samples at bit centres
	// ----------------------------------------
	task automatic grab(input int n, output logic [8:0] d, output logic stop);
		int w;
		d = '0;
		w = 0;
		while (tx_line !== 1'b0 && w < 400) begin
			@(negedge clock);
			w++;
		end
		repeat (BIT / 2) @(negedge clock);
		for (int i = 0; i < n; i++) begin
			repeat (BIT) @(negedge clock);
			d[i] = tx_line;
		end
		repeat (BIT) @(negedge clock);
		stop = tx_line;
	endtask
endmodule
`default_nettype wire

/* tb/async_serial_tx_rx_tb_top.sv */
/*
 Self-checking bench for the serial transmitter and receiver.
 Assumes divisor 0 with high speed, so one tick per clock.
*/
`timescale 1ns/1ns
`default_nettype none
module async_serial_tx_rx_tb_top;
	import asr_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rdata;
	logic receive_pin;
	logic transmit_pin;
	logic transmit_pin_oe;
	logic irq_request;
	int error_cnt = 0;
	int total_checks = 0;
	logic [8:0] got;
	logic [8:0] got2;
	logic stp;
	logic stp2;
	// Receive rows: data, stop level, expected status
	logic [7:0] row_d [3] = '{8'h55, 8'ha3, 8'h0f};
	logic row_stop [3] = '{1'b1, 1'b1, 1'b0};
	logic [7:0] row_st [3] = '{8'h90, 8'h90, 8'h94};

	always #20 clock = ~clock;

	asr_top dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .receive_pin(receive_pin), .transmit_pin(transmit_pin),
		.transmit_pin_oe(transmit_pin_oe), .irq_request(irq_request));
	// Released transmit pin reads as idle mark
	asr_remote remote (.clock(clock), .rx_line(receive_pin), .tx_line(transmit_pin_oe ? transmit_pin : 1'b1));

	// ----------------------------------------
	// Compare, bus cycles, verdict
	// ----------------------------------------
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		total_checks++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [8:0] e);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 chk({1'b0, rdata}, e);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		wrap_up;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		chk({transmit_pin, rdata}, 9'h100);
		chk({7'h0, transmit_pin_oe, irq_request}, 9'h000);
		rd(OFS_TX_STATUS, 9'h002);
		rd(OFS_IRQ_CTRL, 9'h000);
		wr(OFS_DIV_LO, 8'h00);
		wr(OFS_RX_STATUS, 8'h90);
		wr(OFS_BAUD_CTRL, 8'h10);
		wr(OFS_TX_STATUS, 8'h24);
		#1 chk({7'h0, transmit_pin_oe, transmit_pin}, 9'h002);
		wr(OFS_BAUD_CTRL, 8'h00);
		rd(OFS_IRQ_CTRL, 9'h001);
		wr(OFS_IRQ_CTRL, 8'h34);
		#1 chk({8'h0, irq_request}, 9'h001);
		// Single character, shift_empty falls then rises
		wr(OFS_TX_DATA, 8'hc5);
		fork
			remote.grab(8, got, stp);
			rd(OFS_TX_STATUS, 9'h024);
		join
		chk(got, 9'h0c5);
		chk({8'h0, stp}, 9'h001);
		repeat (12) @(posedge clock);
		rd(OFS_TX_STATUS, 9'h026);
		// Nine-bit address character
		wr(OFS_TX_STATUS, 8'h65);
		wr(OFS_TX_DATA, 8'h3a);
		remote.grab(9, got, stp);
		chk(got, 9'h13a);
		repeat (12) @(posedge clock);
		// Back to back, second held in data register
		wr(OFS_TX_STATUS, 8'h24);
		wr(OFS_TX_DATA, 8'h81);
		fork
			begin
				remote.grab(8, got, stp);
				remote.grab(8, got2, stp2);
			end
			begin
				wr(OFS_TX_DATA, 8'h7e);
				@(posedge clock);
				rd(OFS_IRQ_CTRL, 9'h034);
			end
		join
		chk(got, 9'h081);
		chk(got2, 9'h07e);
		// Slow rate: one tick per four clocks, start bit four times longer
		repeat (12) @(posedge clock);
		wr(OFS_TX_STATUS, 8'h20);
		wr(OFS_TX_DATA, 8'hff);
		repeat (40) @(posedge clock);
		chk({8'h0, transmit_pin}, 9'h000);
		repeat (620) @(posedge clock);
		rd(OFS_TX_STATUS, 9'h022);
		wr(OFS_TX_STATUS, 8'h24);
		// Receive rows
		for (int i = 0; i < 3; i++) begin
			remote.send({1'b0, row_d[i]}, 8, row_stop[i]);
			rd(OFS_RX_STATUS, {1'b0, row_st[i]});
			rd(OFS_IRQ_CTRL, 9'h037);
			rd(OFS_RX_DATA, {1'b0, row_d[i]});
		end
		// Nine-bit reception
		wr(OFS_RX_STATUS, 8'hd0);
		remote.send(9'h1a5, 9, 1'b1);
		rd(OFS_RX_STATUS, 9'h0d1);
		rd(OFS_RX_DATA, 9'h0a5);
		// Address detect keeps only characters with the ninth bit set
		wr(OFS_RX_STATUS, 8'hd8);
		remote.send(9'h0a5, 9, 1'b1);
		remote.send(9'h15a, 9, 1'b1);
		rd(OFS_RX_STATUS, 9'h0d9);
		rd(OFS_RX_DATA, 9'h05a);
		// Overrun on third character
		wr(OFS_RX_STATUS, 8'h90);
		remote.send(9'h011, 8, 1'b1);
		remote.send(9'h022, 8, 1'b1);
		remote.send(9'h033, 8, 1'b1);
		rd(OFS_RX_STATUS, 9'h092);
		rd(OFS_RX_DATA, 9'h011);
		rd(OFS_RX_DATA, 9'h022);
		remote.send(9'h044, 8, 1'b1);
		rd(OFS_IRQ_CTRL, 9'h035);
		// Receiver off ignores the line and clears overrun
		wr(OFS_RX_STATUS, 8'h80);
		remote.send(9'h055, 8, 1'b1);
		rd(OFS_IRQ_CTRL, 9'h035);
		rd(OFS_RX_STATUS, 9'h080);
		wr(OFS_RX_STATUS, 8'h90);
		// False start bit then a real character
		remote.glitch(4);
		repeat (40) @(posedge clock);
		rd(OFS_IRQ_CTRL, 9'h035);
		remote.send(9'h05a, 8, 1'b1);
		rd(OFS_RX_DATA, 9'h05a);
		wrap_up;
	end
endmodule
`default_nettype wire
